// ==== mofte_top.sv ====
// monitored 16-point discrete output with open and short fault tests
// assumes host words on clk_sys_i, sense and switch pins asynchronous
// assumes pulse, period and blink counts given in clk_sys_i cycles
// assumes field wiring reports open and short per point, index 0 point 1
`timescale 1ns/100ps
`include "mofte_consts.svh"
module mofte_top #(
    parameter int PERIOD_CYC = `MOFTE_PERIOD_CYC,
    parameter int PULSE_CYC = `MOFTE_PULSE_CYC,
    parameter int BLINK_CYC = `MOFTE_BLINK_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [15:0] cmd_word0_i, // first command word
    input wire logic [15:0] cmd_word1_i, // second word, unused
    input wire logic [1:0] test_sw_i, // two-position switch pins
    input wire logic [15:0] open_sense_i, // open sense pins
    input wire logic [15:0] short_sense_i, // short sense pins
    output logic [15:0] open_word_o, // first input word
    output logic [15:0] short_word_o, // second input word
    output logic [15:0] point_o, // point drive, index 0 is point 1
    output logic [1:0] fault_lamp_o // group fault lamps
);
    // point count, group size and counter width
    localparam int NP = `MOFTE_POINTS;
    localparam int GS = `MOFTE_GROUP_SIZE;
    localparam int CW = `MOFTE_CNT_W;

    // bit reversal: point n sits at word bit 16-n
    // used for the command word in and both status words out
    function automatic mofte_pkg::mofte_word_t mofte_rev(input mofte_pkg::mofte_word_t v);
        mofte_pkg::mofte_word_t r;
        r = '0;
        for (int i = 0; i < NP; i++)
        begin
            r[i] = v[NP-1-i];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] sw_s1_reg, sw_reg; // switch sync
    logic [15:0] open_s1_reg, open_reg; // open sense sync
    logic [15:0] short_s1_reg, short_reg; // short sense sync

    // two flops per pin; no reset, they settle while reset is held
    // only the second flop of each pair feeds the groups
    always_ff @(posedge clk_sys_i)
    begin
        sw_s1_reg <= test_sw_i;
        sw_reg <= sw_s1_reg;
        open_s1_reg <= open_sense_i;
        open_reg <= open_s1_reg;
        short_s1_reg <= short_sense_i;
        short_reg <= short_s1_reg;
    end

    ////////////////////////////////////////////////////////////////
    // pulse sequencer
    mofte_pkg::mofte_state_t state_reg, state_next;
    logic [CW-1:0] cnt_reg, cnt_next; // phase counter
    logic pulse_on; // inverse drive window
    logic sense; // judge pulse result

    // next state and phase count
    // idle waits out the period, pulse and sense make the inverse window
    // drive lags pulse_on by one cycle, so the load has pulse_cyc - 1
    // cycles of inverse drive before the sense cycle judges it
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg + 32'h1;
        sense = 1'b0;
        unique case (state_reg)
            mofte_pkg::MOFTE_IDLE:
            begin
                // wait out the rest of the second
                if (cnt_reg >= CW'(PERIOD_CYC - PULSE_CYC - 1))
                begin
                    state_next = mofte_pkg::MOFTE_PULSE;
                    cnt_next = '0;
                end
            end
            mofte_pkg::MOFTE_PULSE:
            begin
                // hold the inverse drive, sense takes the last cycle
                if (cnt_reg >= CW'(PULSE_CYC - 2))
                begin
                    state_next = mofte_pkg::MOFTE_SENSE;
                    cnt_next = '0;
                end
            end
            mofte_pkg::MOFTE_SENSE:
            begin
                // last pulse cycle, load judged here
                sense = 1'b1;
                state_next = mofte_pkg::MOFTE_IDLE;
                cnt_next = '0;
            end
            default:
            begin
                // not one-hot: back to idle, restart the period
                state_next = mofte_pkg::MOFTE_IDLE;
                cnt_next = '0;
            end
        endcase
    end
    // pulse_on covers pulse and sense states alike
    assign pulse_on = (state_reg != mofte_pkg::MOFTE_IDLE);

    // sequencer registers; reset restarts the period
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_reg <= mofte_pkg::MOFTE_IDLE;
            cnt_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // groups
    mofte_pkg::mofte_word_t cmd_pt; // command by point
    mofte_pkg::mofte_word_t drive_pt, open_pt, short_pt;
    logic [1:0] gfault; // per-group fault
    // word bit 0 is point 16; the second command word is never read
    assign cmd_pt = mofte_rev(cmd_word0_i);

    // one group per switch position; each picks its own test mode
    // the sequencer is shared, a group with its switch off ignores it
    for (genvar g = 0; g < `MOFTE_GROUPS; g++)
    begin : g_grp
        mofte_group #(.W(GS)) u_grp (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .pulse_mode_i(sw_reg[g]),
            .pulse_on_i(pulse_on),
            .sense_i(sense),
            .cmd_i(cmd_pt[g*GS +: GS]),
            .open_det_i(open_reg[g*GS +: GS]),
            .short_det_i(short_reg[g*GS +: GS]),
            .drive_o(drive_pt[g*GS +: GS]),
            .open_o(open_pt[g*GS +: GS]),
            .short_o(short_pt[g*GS +: GS]),
            .fault_o(gfault[g])
        );
    end

    ////////////////////////////////////////////////////////////////
    // lamp blink
    logic [CW-1:0] blink_cnt_reg, blink_cnt_next; // blink timer
    logic blink_reg, blink_next; // blink phase
    logic [1:0] lamp_reg, lamp_next; // lamp drive
    logic [15:0] open_w_reg, open_w_next; // open status word
    logic [15:0] short_w_reg, short_w_next; // short status word

    // blink phase toggles every blink_cyc cycles
    // a lamp is lit only in the on phase and only while its group has a flag
    always_comb
    begin
        blink_cnt_next = blink_cnt_reg + 32'h1;
        blink_next = blink_reg;
        if (blink_cnt_reg >= CW'(BLINK_CYC - 1))
        begin
            blink_cnt_next = '0;
            blink_next = ~blink_reg;
        end
        lamp_next = gfault & {2{blink_reg}};
    end

    // host status words, point n lands on word bit 16-n
    always_comb
    begin
        open_w_next = mofte_rev(open_pt);
        short_w_next = mofte_rev(short_pt);
    end

    // lamp, blink and status registers
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
            lamp_reg <= '0;
            open_w_reg <= '0;
            short_w_reg <= '0;
        end
        else
        begin
            blink_cnt_reg <= blink_cnt_next;
            blink_reg <= blink_next;
            lamp_reg <= lamp_next;
            open_w_reg <= open_w_next;
            short_w_reg <= short_w_next;
        end
    end

    // every data output comes straight from a flop
    assign fault_lamp_o = lamp_reg;
    assign open_word_o = open_w_reg;
    assign short_word_o = short_w_reg;
    assign point_o = drive_pt;
endmodule // mofte_top

// ==== mofte_consts.svh ====
// constants for the monitored output fault test block
// assumes inclusion by bare name from the package and the modules
`ifndef MOFTE_CONSTS_SVH
`define MOFTE_CONSTS_SVH
`define MOFTE_POINTS 16
`define MOFTE_GROUP_SIZE 8
`define MOFTE_GROUPS 2
`define MOFTE_CLK_NS 50
// one test pulse per second, pulse length in microseconds
`define MOFTE_PERIOD_US 1000000
`define MOFTE_PULSE_US 500
`define MOFTE_PERIOD_CYC ((`MOFTE_PERIOD_US * 1000) / `MOFTE_CLK_NS)
`define MOFTE_PULSE_CYC ((`MOFTE_PULSE_US * 1000) / `MOFTE_CLK_NS)
// settle time before sensing a load, in cycles
`define MOFTE_SETTLE_CYC 20
// lamp blink half period, 250 ms
`define MOFTE_BLINK_US 250000
`define MOFTE_BLINK_CYC ((`MOFTE_BLINK_US * 1000) / `MOFTE_CLK_NS)
`define MOFTE_CNT_W 32
`endif

// ==== mofte_pkg.sv ====
// types for the monitored output fault test block
// assumes mofte_consts.svh is on the include path
`include "mofte_consts.svh"
package mofte_pkg;
    // pulse sequencer states, one-hot
    typedef enum logic [2:0] {
        MOFTE_IDLE = 3'b001,
        MOFTE_PULSE = 3'b010,
        MOFTE_SENSE = 3'b100
    } mofte_state_t;
    typedef logic [`MOFTE_POINTS-1:0] mofte_word_t;
endpackage

// ==== mofte_group.sv ====
// one group of eight monitored points: fault flags and drive
// assumes synchronised sense inputs and a shared pulse sequencer
`timescale 1ns/100ps
`include "mofte_consts.svh"
module mofte_group #(
    parameter int W = `MOFTE_GROUP_SIZE
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic pulse_mode_i, // sampled switch for this group
    input wire logic pulse_on_i, // inverted pulse window
    input wire logic sense_i, // end of pulse, judge load
    input wire logic [W-1:0] cmd_i, // commanded levels
    input wire logic [W-1:0] open_det_i, // synchronised open sense
    input wire logic [W-1:0] short_det_i, // synchronised short sense
    output logic [W-1:0] drive_o, // output drive
    output logic [W-1:0] open_o, // open flags
    output logic [W-1:0] short_o, // short flags
    output logic fault_o // any fault in group
);
    logic [W-1:0] open_reg, open_next; // open fault flags
    logic [W-1:0] short_reg, short_next; // short fault flags
    logic [W-1:0] cmd_prev_reg; // last command, for change clear
    logic [W-1:0] drive_reg, drive_next; // registered drive

    ////////////////////////////////////////////////////////////////
    // next flags and drive
    always_comb
    begin
        open_next = open_reg;
        short_next = short_reg;
        if (pulse_mode_i)
        begin
            // full test: judge open at pulse end, short on every driven cycle
            if (sense_i)
            begin
                open_next = open_reg | open_det_i;
            end
            short_next = short_reg | (short_det_i & drive_reg);
            // short cleared only when command goes off with no short, open on any command change with no open
            short_next = short_next & ~(~cmd_i & cmd_prev_reg & ~short_det_i);
            open_next = open_next & ~((cmd_i ^ cmd_prev_reg) & ~open_det_i);
        end
        else
        begin
            // clear on opposite command, set wins over clear
            open_next = open_reg & ~(cmd_i & ~cmd_prev_reg);
            short_next = short_reg & ~(~cmd_i & cmd_prev_reg);
            open_next = open_next | (open_det_i & ~cmd_i);
            short_next = short_next | (short_det_i & cmd_i);
        end
        // pulse only in pulse mode, short forces off
        if (pulse_mode_i && pulse_on_i)
        begin
            drive_next = ~cmd_i & ~short_next;
        end
        else
        begin
            drive_next = cmd_i & ~short_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            open_reg <= '0;
            short_reg <= '0;
            cmd_prev_reg <= '0;
            drive_reg <= '0;
        end
        else
        begin
            open_reg <= open_next;
            short_reg <= short_next;
            cmd_prev_reg <= cmd_i;
            drive_reg <= drive_next;
        end
    end

    assign drive_o = drive_reg;
    assign open_o = open_reg;
    assign short_o = short_reg;
    assign fault_o = |open_reg | |short_reg;
endmodule // mofte_group

// ==== mofte_checker.sv ====
// checker for mofte_top: drive, fault flags, lamps and pulse test
// assumes bind onto mofte_top with its cycle parameters
`timescale 1ns/100ps
module mofte_checker #(
    parameter int PERIOD_CYC = 200,
    parameter int PULSE_CYC = 10,
    parameter int BLINK_CYC = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [15:0] cmd_word0_i,
    input wire logic [1:0] test_sw_i,
    input wire logic [15:0] open_sense_i,
    input wire logic [15:0] short_sense_i,
    input wire logic [15:0] open_word_o,
    input wire logic [15:0] short_word_o,
    input wire logic [15:0] point_o,
    input wire logic [1:0] fault_lamp_o
);
    localparam int GAP_MAX = PERIOD_CYC + PULSE_CYC + 8; // longest wait for a pulse
    localparam int BLINK_WIN = BLINK_CYC + 2; // one half period plus slack
    logic [15:0] cmd_rev; // command in point order
    logic [15:0] sht_rev; // short flags in point order
    logic [15:0] cmd_q_reg; // command as the drive sees it
    logic [2:0] q0_reg; // cycles group 1 switch off
    logic [2:0] q1_reg; // cycles group 2 switch off
    int gap_reg; // cycles group 1 drive equals command
    logic lamp1_q_reg; // group 2 lamp one cycle back
    int still_reg; // cycles since group 2 lamp last changed
    ////////////////////////////////////////////////////////////
    // bit reversal into point order
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            cmd_rev[i] = cmd_word0_i[15 - i];
            sht_rev[i] = short_word_o[15 - i];
        end
    end
    // counters; switch counters saturate so sync delay is covered
    always_ff @(posedge clk_sys_i)
    begin
        cmd_q_reg <= cmd_rev;
        q0_reg <= (rst_i || test_sw_i[0]) ? 3'h0 : q0_reg + {2'h0, q0_reg != 3'h7};
        q1_reg <= (rst_i || test_sw_i[1]) ? 3'h0 : q1_reg + {2'h0, q1_reg != 3'h7};
        gap_reg <= (rst_i || !test_sw_i[0] || point_o[7:0] != cmd_q_reg[7:0]) ? 0 : gap_reg + 1;
        lamp1_q_reg <= fault_lamp_o[1];
        still_reg <= (rst_i || fault_lamp_o[1] != lamp1_q_reg) ? 0 : still_reg + 1;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_short_seen;
        (short_sense_i[15] && point_o[15]) [*3];
    endsequence
    sequence s_open_seen;
        (q0_reg == 3'h7 && open_sense_i[0] && !point_o[0] && !cmd_word0_i[15]) [*4];
    endsequence
    sequence s_open_release;
        q0_reg == 3'h7 && open_word_o[15] && $rose(cmd_word0_i[15]);
    endsequence
    sequence s_g2_fault;
        (short_word_o[7:0] != 8'h00) [*8];
    endsequence
    sequence s_g2_clean;
        ((open_word_o[7:0] | short_word_o[7:0]) == 8'h00) [*3];
    endsequence
    AST_GRP1_NO_PULSE: assert property (q0_reg == 3'h7 |-> (point_o[7:0] & ~cmd_q_reg[7:0]) == 8'h00)
        else $error("group 1 driven beyond command with switch off");
    AST_GRP2_NO_PULSE: assert property (q1_reg == 3'h7 |-> (point_o[15:8] & ~cmd_q_reg[15:8]) == 8'h00)
        else $error("group 2 driven beyond command with switch off");
    AST_SHORT_OFF: assert property ((point_o & sht_rev) == 16'h0000)
        else $error("shorted point still driven");
    AST_SHORT_SET: assert property (s_short_seen |-> ##[0:3] short_word_o[0])
        else $error("short on point 16 not flagged");
    AST_OPEN_SET: assert property (s_open_seen |-> ##[0:3] open_word_o[15])
        else $error("open on point 1 not flagged");
    AST_OPEN_CLEAR: assert property (s_open_release |-> ##[0:3] !open_word_o[15])
        else $error("open flag kept after opposite command");
    AST_LAMP_BLINK: assert property (s_g2_fault ##1 s_g2_fault |-> still_reg <= BLINK_WIN)
        else $error("group 2 lamp not flashing");
    AST_LAMP_DARK: assert property (s_g2_clean |-> !fault_lamp_o[1])
        else $error("group 2 lamp lit without fault");
    AST_PULSE_DUE: assert property (gap_reg <= GAP_MAX)
        else $error("no inverse pulse on group 1 in time");
endmodule // mofte_checker
bind mofte_top mofte_checker #(.PERIOD_CYC(PERIOD_CYC), .PULSE_CYC(PULSE_CYC),
    .BLINK_CYC(BLINK_CYC)) u_chk (.clk_sys_i, .rst_i, .cmd_word0_i, .test_sw_i,
    .open_sense_i, .short_sense_i, .open_word_o, .short_word_o, .point_o, .fault_lamp_o);

// ==== mofte_load.sv ====
// field wiring model: open and short sensing per point
// assumes index 0 is point 1 on every vector
`timescale 1ns/100ps
module mofte_load (
    input wire logic [15:0] point_i, // drive from the block
    input wire logic [15:0] open_flt_i, // points with broken wiring
    input wire logic [15:0] short_flt_i, // points shorted
    output logic [15:0] open_sense_o, // test current finds no load
    output logic [15:0] short_sense_o // overcurrent seen
);
    // an open is only visible while the point is off
    assign open_sense_o = open_flt_i & ~point_i;
    // a short only draws current while driven on
    assign short_sense_o = short_flt_i & point_i;
endmodule // mofte_load

// ==== mofte_top_bench.sv ====
// bench for mofte_top: drive mapping, faults, lamps, pulse test
// assumes mofte_load as field wiring and shortened cycle counts
`timescale 1ns/100ps
module mofte_top_bench;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] cmd0 = 16'h0000; // first command word
    logic [15:0] cmd1 = 16'h0000; // second command word
    logic [1:0] sw = 2'h0; // test switch
    logic [15:0] o_flt = 16'h0000; // open wiring faults
    logic [15:0] s_flt = 16'h0000; // shorted points
    logic [15:0] o_sns, s_sns, o_word, s_word, pt;
    logic [1:0] lamp;
    int err_total = 0;
    int n_tests = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    mofte_top #(.PERIOD_CYC(200), .PULSE_CYC(10), .BLINK_CYC(8)) uut (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .cmd_word0_i(cmd0), .cmd_word1_i(cmd1), .test_sw_i(sw),
        .open_sense_i(o_sns), .short_sense_i(s_sns), .open_word_o(o_word),
        .short_word_o(s_word), .point_o(pt), .fault_lamp_o(lamp));
    mofte_load u_load (.point_i(pt), .open_flt_i(o_flt), .short_flt_i(s_flt),
        .open_sense_o(o_sns), .short_sense_o(s_sns));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    // point order from word order: point n is word bit 16-n
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++)
        begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // count cycles each group differs from an all-on command
    task automatic watch(input int n, output int a, output int b);
        a = 0;
        b = 0;
        repeat (n)
        begin
            tick(1);
            a += (pt[7:0] != 8'hff);
            b += (pt[15:8] != 8'hff);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_drive();
        logic [15:0] pats [3] = '{16'h0001, 16'h8000, 16'ha5c3};
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk_sys_i);
            cmd0 <= pats[k];
            cmd1 <= ~pats[k];
            tick(2);
            check(pt, rev16(pats[k]), "drive");
        end
        $display("drive test done");
    endtask
    task automatic t_open();
        @(posedge clk_sys_i);
        cmd0 <= 16'h0000;
        o_flt <= 16'h0001;
        tick(8);
        check(o_word, 16'h8000, "open flag");
        @(posedge clk_sys_i);
        cmd0 <= 16'h8000;
        tick(8);
        check(o_word, 16'h0000, "open clear");
        @(posedge clk_sys_i);
        o_flt <= 16'h0000;
        $display("open test done");
    endtask
    task automatic t_short();
        logic [1:0] seen = 2'h0;
        @(posedge clk_sys_i);
        cmd0 <= 16'h0001;
        s_flt <= 16'h8000;
        tick(8);
        check(s_word, 16'h0001, "short flag");
        check(pt, 16'h0000, "short forced off");
        repeat (20)
        begin
            tick(1);
            seen |= {lamp[1], ~lamp[1]};
        end
        check({14'h0, seen}, 16'h0003, "lamp flash");
        @(posedge clk_sys_i);
        s_flt <= 16'h0000;
        cmd0 <= 16'h0000;
        tick(5);
        check(s_word, 16'h0000, "short clear");
        $display("short test done");
    endtask
    task automatic t_pulse();
        int a;
        int b;
        @(posedge clk_sys_i);
        cmd0 <= 16'hffff;
        sw <= 2'h1;
        o_flt <= 16'h0001;
        watch(240, a, b);
        check({15'h0, a > 0}, 16'h0001, "group 1 pulsed");
        check(b[15:0], 16'h0000, "group 2 steady");
        check(o_word, 16'h8000, "pulse open flag");
        @(posedge clk_sys_i);
        sw <= 2'h2;
        o_flt <= 16'h0000;
        tick(6);
        watch(240, a, b);
        check(a[15:0], 16'h0000, "group 1 now steady");
        check({15'h0, b > 0}, 16'h0001, "group 2 pulsed");
        $display("pulse test done");
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_drive();
        t_open();
        t_short();
        t_pulse();
        conclude();
    end
    // watchdog against a hang
    initial
    begin
        repeat (1500) @(posedge clk_sys_i);
        err_total++;
        conclude();
    end
endmodule // mofte_top_bench
